// [verilog/dxt_transfer.v]
// execution-phase byte transfer engine: dma, interrupt and polled modes with fifo triggers
`timescale 1ns/10ps
`include "dxt_consts.vh"
module dxt_transfer #(
	parameter CLK_NS = `DXT_CLK_NS,
	parameter GAP_NS = `DXT_GAP_NS
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        aen,
	input  wire        dack_n,
	input  wire        tc,
	input  wire        ior_n,
	input  wire        iow_n,
	input  wire [7:0]  dma_wdata,
	output wire [7:0]  dma_rdata,
	output wire        drq,
	output wire        irq,
	input  wire        disk_rd_valid,
	input  wire [7:0]  disk_rd_data,
	output wire        disk_hold,
	input  wire        disk_wr_take,
	output wire [7:0]  disk_wr_data,
	output wire        disk_wr_avail
);
	// ----------------------------------------------------------------
	// constants and state codes
	// ----------------------------------------------------------------
	localparam GAP_CYC   = (GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam ST_IDLE   = 3'h0;
	localparam ST_EXEC   = 3'h1;
	localparam ST_DRAIN  = 3'h2;
	localparam ST_FILL   = 3'h3;
	localparam ST_RESULT = 3'h4;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg         dir_reg;
	reg         nodma_reg;
	reg         dmaen_reg;
	reg         fifoen_reg;
	reg         burstd_reg;
	reg         alt_reg;
	reg  [3:0]  thr_reg;
	reg  [15:0] seclen_reg;
	reg  [7:0]  seccnt_reg;
	reg  [7:0]  sec_left_reg;
	reg  [15:0] dcnt_reg;
	reg  [15:0] hcnt_reg;
	reg         rd_secend_reg;
	reg         wr_secfull_reg;
	reg         ovr_reg;
	reg         unr_reg;
	reg         tc_reg;
	reg         sess_reg;
	reg         hold_reg;
	reg         seen_reg;
	reg         dack_n_q;
	reg         ior_n_q;
	reg         iow_n_q;
	reg         drq_reg;
	reg         irq_reg;
	reg         endirq_reg;
	reg  [31:0] prdata_reg;
	reg  [31:0] rd_mux;
	reg  [7:0]  dma_rdata_reg;
	reg  [7:0]  disk_wr_data_reg;

	wire [7:0]  fifo_dout;
	wire [4:0]  fifo_cnt;
	wire        gap_busy;

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	wire in_exec  = (state_reg == ST_EXEC);
	wire in_drain = (state_reg == ST_DRAIN);
	wire in_fill  = (state_reg == ST_FILL);
	wire in_res   = (state_reg == ST_RESULT);
	wire in_xfer  = in_exec | in_drain;
	wire dma_mode = ~nodma_reg & dmaen_reg;
	wire fifo_on  = fifoen_reg | (alt_reg & dma_mode);
	wire [3:0] thr_eff = fifoen_reg ? thr_reg : (fifo_on ? 4'hF : 4'h0);
	// with the fifo off it behaves as a one-byte holding register
	wire [4:0] cap    = fifo_on ? `DXT_FIFO_FULL : 5'h01;
	wire [4:0] rd_lim = fifo_on ? (`DXT_FIFO_FULL - {1'b0, thr_eff}) : 5'h01;
	wire fifo_empty = (fifo_cnt == 5'h00);
	wire full_eff   = (fifo_cnt >= cap);

	// ----------------------------------------------------------------
	// host side strobes
	// ----------------------------------------------------------------
	wire dack_fall  = dack_n_q & ~dack_n;
	wire dack_rise  = ~dack_n_q & dack_n;
	// strobe end is judged against last cycle's dack so a joint release still counts
	wire strobe_end = ~dack_n_q & ((~ior_n_q & ior_n) | (~iow_n_q & iow_n));
	wire dma_xfer   = dma_mode & in_xfer & (strobe_end | (dack_rise & ~seen_reg));
	wire apb_set    = psel & ~penable;
	wire apb_acc    = psel & penable;
	wire data_hit   = apb_acc & (paddr == `DXT_OFS_DATA) & ~aen;
	wire cpu_xfer   = ~dma_mode & in_xfer & data_hit & (pwrite ^ dir_reg);
	wire host_xfer  = dma_xfer | cpu_xfer;
	wire tc_hit     = dma_mode & in_xfer & tc & ~dack_n;

	// ----------------------------------------------------------------
	// disk side and fifo moves
	// ----------------------------------------------------------------
	wire rd_disk = dir_reg & in_xfer & disk_rd_valid & ~rd_secend_reg;
	wire ovr_hit = rd_disk & in_exec & full_eff;
	wire wr_disk = ~dir_reg & disk_wr_take & (in_exec | in_fill);
	wire unr_hit = wr_disk & in_exec & fifo_empty;
	wire push_rd = rd_disk & in_exec & ~full_eff;
	wire pop_wr  = wr_disk & in_exec & ~fifo_empty;
	wire pop_rd  = dir_reg & host_xfer & ~fifo_empty;
	wire push_wr = ~dir_reg & host_xfer & in_exec & ~full_eff & ~wr_secfull_reg;
	wire push    = push_rd | push_wr;
	wire pop     = pop_rd | pop_wr;
	wire [7:0] fifo_din = dir_reg ? disk_rd_data : (dma_mode ? dma_wdata : pwdata[7:0]);
	wire [4:0] cnt_nx   = fifo_cnt + {4'h0, push} - {4'h0, pop};

	// ----------------------------------------------------------------
	// sector accounting
	// ----------------------------------------------------------------
	wire        dcnt_inc     = rd_disk | wr_disk;
	wire [15:0] dcnt_nx      = dcnt_reg + {15'h0000, dcnt_inc};
	wire [15:0] hcnt_nx      = hcnt_reg + {15'h0000, push_wr};
	wire        disk_sec_end = dcnt_inc & (dcnt_nx == seclen_reg);
	wire        wr_full_set  = push_wr & (hcnt_nx == seclen_reg);
	wire        wr_block     = wr_secfull_reg | wr_full_set;
	wire        last_sec     = (sec_left_reg == 8'h01);
	wire        rd_sec_done  = dir_reg & in_xfer & rd_secend_reg & (cnt_nx == 5'h00);
	wire        wr_sec_done  = ~dir_reg & (in_exec | in_fill) & disk_sec_end;
	wire        sec_done     = rd_sec_done | wr_sec_done;
	// after an error the current sector is the last one
	wire        finish       = tc_hit | (sec_done & (last_sec | ~in_exec));
	wire        sec_next     = sec_done & ~finish;

	// ----------------------------------------------------------------
	// request generation
	// ----------------------------------------------------------------
	wire rd_trig  = (cnt_nx >= rd_lim) | ((rd_secend_reg | in_drain) & (cnt_nx != 5'h00));
	wire wr_trig  = in_exec & (cnt_nx <= {1'b0, thr_eff}) & (cnt_nx < cap) & ~wr_block;
	wire sess_end = dir_reg ? (cnt_nx == 5'h00) : ((cnt_nx >= cap) | wr_block);
	wire sess_nx  = in_xfer & ~finish & ~ovr_hit & ~unr_hit &
			(sess_reg ? ~sess_end : (dir_reg ? rd_trig : wr_trig));
	wire per_byte = ~fifoen_reg | burstd_reg;
	wire hold_nx  = dack_n ? 1'b0 : (hold_reg | (dack_fall & per_byte & dma_mode));
	wire gap_start = host_xfer & fifoen_reg & burstd_reg;
	wire req_nx   = sess_nx & ~hold_nx & ~gap_start & ~gap_busy;
	wire res_rd   = in_res & apb_acc & ~pwrite & (paddr == `DXT_OFS_RESULT);
	wire ctrl_wr  = apb_acc & pwrite & (paddr == `DXT_OFS_CTRL);
	wire start    = ctrl_wr & pwdata[`DXT_CTRL_START] & (state_reg == ST_IDLE);
	wire endirq_nx = (endirq_reg & ~res_rd) | (state_next == ST_RESULT & ~in_res);

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	dxt_fifo #(
		.W  (8),
		.AW (`DXT_FIFO_AW)
	) u_fifo (
		.clk   (pclk),
		.rst_n (presetn),
		.flush (start | finish),
		.push  (push),
		.pop   (pop),
		.din   (fifo_din),
		.dout  (fifo_dout),
		.count (fifo_cnt)
	);

	dxt_gap #(
		.CYC (GAP_CYC)
	) u_gap (
		.clk   (pclk),
		.rst_n (presetn),
		.start (gap_start),
		.busy  (gap_busy)
	);

	// ----------------------------------------------------------------
	// phase sequencing
	// ----------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_IDLE: begin
			if (start)
				state_next = ST_EXEC;
		end
		ST_EXEC: begin
			if (finish)
				state_next = ST_RESULT;
			else if (ovr_hit)
				state_next = ST_DRAIN;
			else if (unr_hit)
				state_next = ST_FILL;
		end
		ST_DRAIN, ST_FILL: begin
			if (finish)
				state_next = ST_RESULT;
		end
		ST_RESULT: begin
			if (res_rd)
				state_next = ST_IDLE;
		end
		default: state_next = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// control registers and engine state
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= ST_IDLE;
			dir_reg        <= 1'b0;
			nodma_reg      <= 1'b0;
			dmaen_reg      <= 1'b0;
			fifoen_reg     <= 1'b0;
			burstd_reg     <= 1'b0;
			alt_reg        <= 1'b0;
			thr_reg        <= `DXT_RST_THR;
			seclen_reg     <= `DXT_RST_SECLEN;
			seccnt_reg     <= `DXT_RST_SECCNT;
			sec_left_reg   <= 8'h00;
			dcnt_reg       <= 16'h0000;
			hcnt_reg       <= 16'h0000;
			rd_secend_reg  <= 1'b0;
			wr_secfull_reg <= 1'b0;
			ovr_reg        <= 1'b0;
			unr_reg        <= 1'b0;
			tc_reg         <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (ctrl_wr) begin
				dir_reg    <= pwdata[`DXT_CTRL_DIR];
				nodma_reg  <= pwdata[`DXT_CTRL_NODMA];
				dmaen_reg  <= pwdata[`DXT_CTRL_DMAEN];
				fifoen_reg <= pwdata[`DXT_CTRL_FIFOEN];
				burstd_reg <= pwdata[`DXT_CTRL_BURSTD];
				alt_reg    <= pwdata[`DXT_CTRL_ALT];
				thr_reg    <= pwdata[`DXT_CTRL_THR_HI:`DXT_CTRL_THR_LO];
			end
			if (apb_acc & pwrite & (paddr == `DXT_OFS_SECLEN))
				seclen_reg <= pwdata[15:0];
			if (apb_acc & pwrite & (paddr == `DXT_OFS_SECCNT))
				seccnt_reg <= pwdata[7:0];
			if (start) begin
				sec_left_reg   <= seccnt_reg;
				dcnt_reg       <= 16'h0000;
				hcnt_reg       <= 16'h0000;
				rd_secend_reg  <= 1'b0;
				wr_secfull_reg <= 1'b0;
				ovr_reg        <= 1'b0;
				unr_reg        <= 1'b0;
				tc_reg         <= 1'b0;
			end else if (sec_next) begin
				sec_left_reg   <= sec_left_reg - 8'h01;
				dcnt_reg       <= 16'h0000;
				hcnt_reg       <= 16'h0000;
				rd_secend_reg  <= 1'b0;
				wr_secfull_reg <= 1'b0;
			end else begin
				dcnt_reg <= dcnt_nx;
				hcnt_reg <= hcnt_nx;
				if (dir_reg & disk_sec_end)
					rd_secend_reg <= 1'b1;
				if (wr_full_set)
					wr_secfull_reg <= 1'b1;
				if (ovr_hit)
					ovr_reg <= 1'b1;
				if (unr_hit)
					unr_reg <= 1'b1;
				if (tc_hit)
					tc_reg <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// request pins and strobe tracking
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sess_reg      <= 1'b0;
			hold_reg      <= 1'b0;
			seen_reg      <= 1'b0;
			dack_n_q      <= 1'b1;
			ior_n_q       <= 1'b1;
			iow_n_q       <= 1'b1;
			drq_reg       <= 1'b0;
			irq_reg       <= 1'b0;
			endirq_reg    <= 1'b0;
			dma_rdata_reg <= 8'h00;
		end else begin
			sess_reg      <= sess_nx;
			hold_reg      <= hold_nx;
			seen_reg      <= dack_n ? 1'b0 : (seen_reg | ~ior_n | ~iow_n);
			dack_n_q      <= dack_n;
			ior_n_q       <= ior_n;
			iow_n_q       <= iow_n;
			drq_reg       <= dma_mode & req_nx;
			irq_reg       <= endirq_nx | (~dma_mode & req_nx);
			endirq_reg    <= endirq_nx;
			dma_rdata_reg <= fifo_dout;
		end
	end

	// ----------------------------------------------------------------
	// disk write byte: held on underrun so the sector tail repeats it
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			disk_wr_data_reg <= 8'h00;
		else if (pop_wr)
			disk_wr_data_reg <= fifo_dout;
	end

	// ----------------------------------------------------------------
	// register read path
	// ----------------------------------------------------------------
	wire st_rqm  = (state_reg == ST_IDLE) | in_res | (in_xfer & ~dma_mode & sess_reg);
	wire st_dio  = in_res | (in_xfer & dir_reg);
	wire st_ndma = in_xfer & ~dma_mode;
	wire st_busy = ~(state_reg == ST_IDLE);
	wire [1:0] res_code = (ovr_reg | unr_reg) ? 2'h1 : 2'h0;
	wire addr_ok = (paddr == `DXT_OFS_CTRL) | (paddr == `DXT_OFS_STATUS) |
			(paddr == `DXT_OFS_DATA) | (paddr == `DXT_OFS_SECLEN) |
			(paddr == `DXT_OFS_SECCNT) | (paddr == `DXT_OFS_RESULT);

	always @* begin
		case (paddr)
		`DXT_OFS_CTRL:   rd_mux = {20'h00000, thr_reg, 1'b0, alt_reg, burstd_reg,
				fifoen_reg, dmaen_reg, nodma_reg, dir_reg, 1'b0};
		`DXT_OFS_STATUS: rd_mux = {11'h000, fifo_cnt, 6'h00, unr_reg, ovr_reg,
				st_rqm, st_dio, st_ndma, st_busy, 4'h0};
		`DXT_OFS_DATA:   rd_mux = {24'h000000, fifo_dout};
		`DXT_OFS_SECLEN: rd_mux = {16'h0000, seclen_reg};
		`DXT_OFS_SECCNT: rd_mux = {24'h000000, seccnt_reg};
		`DXT_OFS_RESULT: rd_mux = {24'h000000, res_code, 3'h0, unr_reg, ovr_reg, tc_reg};
		default:         rd_mux = 32'h00000000;
		endcase
	end

	// read data is caught in the setup cycle so the access cycle can answer at once
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (apb_set & ~pwrite)
			prdata_reg <= rd_mux;
	end

	assign prdata        = prdata_reg;
	assign pready        = 1'b1;
	assign pslverr       = apb_acc & ~addr_ok;
	assign drq           = drq_reg;
	assign irq           = irq_reg;
	assign dma_rdata     = dma_rdata_reg;
	assign disk_hold     = rd_secend_reg;
	assign disk_wr_data  = disk_wr_data_reg;
	assign disk_wr_avail = ~dir_reg & (in_fill | (in_exec & ~fifo_empty));
endmodule

// [verilog/dxt_consts.vh]
// offsets, field positions, reset values and timing for the exec-phase transfer block
`ifndef DXT_CONSTS_VH
`define DXT_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DXT_OFS_CTRL    8'h00
`define DXT_OFS_STATUS  8'h04
`define DXT_OFS_DATA    8'h08
`define DXT_OFS_SECLEN  8'h0C
`define DXT_OFS_SECCNT  8'h10
`define DXT_OFS_RESULT  8'h14

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define DXT_CTRL_START  0
`define DXT_CTRL_DIR    1
`define DXT_CTRL_NODMA  2
`define DXT_CTRL_DMAEN  3
`define DXT_CTRL_FIFOEN 4
`define DXT_CTRL_BURSTD 5
`define DXT_CTRL_ALT    6
`define DXT_CTRL_THR_LO 8
`define DXT_CTRL_THR_HI 11

// ----------------------------------------------------------------
// reset values and fifo geometry
// ----------------------------------------------------------------
`define DXT_RST_THR     4'h0
`define DXT_RST_SECLEN  16'h0200
`define DXT_RST_SECCNT  8'h01
`define DXT_FIFO_AW     4
`define DXT_FIFO_FULL   5'h10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DXT_CLK_NS      40
`define DXT_GAP_NS      350

`endif

// [verilog/dxt_fifo.v]
// byte fifo between the host side and the disk side of the transfer block
`timescale 1ns/10ps
module dxt_fifo #(
	parameter W  = 8,
	parameter AW = 4
) (
	input  wire          clk,
	input  wire          rst_n,
	input  wire          flush,
	input  wire          push,
	input  wire          pop,
	input  wire [W-1:0]  din,
	output wire [W-1:0]  dout,
	output wire [AW:0]   count
);
	reg  [W-1:0]  mem [0:(1<<AW)-1];
	reg  [AW-1:0] wp_reg;
	reg  [AW-1:0] rp_reg;
	reg  [AW:0]   cnt_reg;

	assign dout  = mem[rp_reg];
	assign count = cnt_reg;

	// caller guarantees no push when full and no pop when empty
	always @(posedge clk) begin
		if (push)
			mem[wp_reg] <= din;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg  <= {AW{1'b0}};
			rp_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else if (flush) begin
			wp_reg  <= {AW{1'b0}};
			rp_reg  <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_reg <= wp_reg + {{(AW-1){1'b0}}, 1'b1};
			if (pop)
				rp_reg <= rp_reg + {{(AW-1){1'b0}}, 1'b1};
			if (push & ~pop)
				cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
			else if (pop & ~push)
				cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
		end
	end
endmodule

// [verilog/dxt_gap.v]
// request gap timer for non-burst transfers
`timescale 1ns/10ps
module dxt_gap #(
	parameter CYC = 9
) (
	input  wire clk,
	input  wire rst_n,
	input  wire start,
	output wire busy
);
	reg [7:0] cnt_reg;

	assign busy = (cnt_reg != 8'h00);

	// restart on every transfer so the gap always follows the latest byte
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_reg <= 8'h00;
		else if (start)
			cnt_reg <= CYC[7:0];
		else if (busy)
			cnt_reg <= cnt_reg - 8'h01;
	end
endmodule

// [verif/dxt_transfer_asserts.sv]
// assertion checker watching the transfer block ports
`timescale 1ns/10ps
`include "dxt_consts.vh"
module dxt_chk (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        dack_n,
	input wire        ior_n,
	input wire        iow_n,
	input wire        drq,
	input wire        irq,
	input wire        disk_wr_take,
	input wire [7:0]  disk_wr_data
);
	// ----------------
	// control mirror
	// ----------------
	reg  [31:0] ctrl_reg;
	wire        dma_on;
	wire        fifo_on;
	wire        cnt_ev;
	assign dma_on = !ctrl_reg[`DXT_CTRL_NODMA] && ctrl_reg[`DXT_CTRL_DMAEN];
	assign fifo_on = ctrl_reg[`DXT_CTRL_FIFOEN];
	// mode bits change on any control write, as in the block, so the last write is enough
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_reg <= 32'h0;
		else if (psel && penable && pwrite && paddr == `DXT_OFS_CTRL)
			ctrl_reg <= pwdata;
	end
	assign cnt_ev = dma_on && fifo_on && ctrl_reg[`DXT_CTRL_BURSTD] && !dack_n;
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; psel |-> pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_slverr; psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h14);
	endproperty
	a_slverr: assert property (p_slverr) else $error("pslverr wrong");
	property p_rdata; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_rdata: assert property (p_rdata) else $error("prdata moved");
	property p_nodma; !dma_on && !$past(dma_on) |-> !drq; endproperty
	a_nodma: assert property (p_nodma) else $error("drq outside dma mode");
	property p_dack; dma_on && !fifo_on && $fell(dack_n) |=> !drq; endproperty
	a_dack: assert property (p_dack) else $error("drq kept after dack");
	// nine low cycles from the strobe edge: the shortest gap that still covers 350 ns
	property p_gap; cnt_ev && ($rose(ior_n) || $rose(iow_n)) |=> !drq [*8] ##1 !drq; endproperty
	a_gap: assert property (p_gap) else $error("gap too short");
	property p_irq; dma_on && irq && psel && penable && !pwrite && paddr == `DXT_OFS_RESULT
		|=> !irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq kept");
	property p_wrd; !disk_wr_take && !psel && !$past(psel) |=> $stable(disk_wr_data);
	endproperty
	a_wrd: assert property (p_wrd) else $error("disk byte moved");
	c_gap: cover property (cnt_ev && $rose(ior_n));
	c_dack: cover property (dma_on && $fell(dack_n));
	c_irq: cover property ($rose(irq));
endmodule

// [verif/dxt_isa_dma.sv]
// behavioural dma controller serving the request line
`timescale 1ns/10ps
module dxt_isa_dma (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       en,
	input  wire       dir,
	input  wire       tc_req,
	input  wire       tc_str,
	input  wire       vfy,
	input  wire       drq,
	input  wire [7:0] dma_rdata,
	output reg        dack_n,
	output reg        aen,
	output reg        tc,
	output reg        ior_n,
	output reg        iow_n,
	output reg  [7:0] dma_wdata
);
	logic [7:0] rxq[$];
	logic [7:0] wq[$];
	int         slow;
	initial begin
		dack_n = 1'b1;
		aen = 1'b0;
		tc = 1'b0;
		ior_n = 1'b1;
		iow_n = 1'b1;
		dma_wdata = 8'h00;
	end
	// ----------------
	// one acknowledge pulse per byte
	// ----------------
	always begin
		@(posedge pclk);
		if (presetn && en && drq) begin
			dack_n <= 1'b0;
			aen <= 1'b1;
			tc <= tc_req;
			// verify cycles pulse dack alone, with no read strobe
			if (dir)
				ior_n <= vfy;
			else begin
				iow_n <= 1'b0;
				dma_wdata <= wq.size() ? wq.pop_front() : 8'h00;
			end
			repeat (2) @(posedge pclk);
			if (dir)
				rxq.push_back(dma_rdata);
			ior_n <= 1'b1;
			iow_n <= 1'b1;
			@(posedge pclk);
			dack_n <= 1'b1;
			aen <= 1'b0;
			tc <= 1'b0;
			// released bus shows the inverse so no stale byte is mistaken for data
			dma_wdata <= ~dma_wdata;
			// at least two idle edges: a late drq drop must not buy an extra byte
			slow = $urandom_range(2, 5);
			repeat (slow) @(posedge pclk);
		end else
			tc <= tc_str;
	end
endmodule

// [verif/dxt_transfer_bench.sv]
// self-checking bench for the exec-phase transfer block
`timescale 1ns/10ps
`include "dxt_consts.vh"
bind dxt_transfer dxt_chk dxt_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dack_n(dack_n), .ior_n(ior_n), .iow_n(iow_n),
	.drq(drq), .irq(irq), .disk_wr_take(disk_wr_take), .disk_wr_data(disk_wr_data));
module dxt_transfer_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        aen_f = 1'b0;
	logic        rd_v = 1'b0;
	logic [7:0]  rd_d = 8'h00;
	logic        wr_t = 1'b0;
	logic        en = 1'b0;
	logic        dir = 1'b0;
	logic        tc_req = 1'b0;
	logic        tc_str = 1'b0;
	logic        vfy = 1'b0;
	wire  [31:0] prdata;
	wire         pready, pslverr, aen_m, dack_n, tc, ior_n, iow_n, drq, irq, hold, avail;
	wire  [7:0]  dwd, drd, wr_d;
	logic [7:0]  expq[$];
	logic [31:0] r;
	logic        e;
	logic [7:0]  b, fb;
	int          failures = 0;
	int          total_checks = 0;
	// mode field order: alt, burst off, fifo, dma en, no-dma, dir, start
	logic [6:0]  rdm[4] = '{7'b0011011, 7'b0111011, 7'b0001011, 7'b1001011};
	logic [6:0]  wrm[4] = '{7'b0001001, 7'b1001001, 7'b0011001, 7'b0111001};
	logic [3:0]  rth[4] = '{4'hF, 4'h4, 4'h0, 4'h0};
	logic [3:0]  wth[4] = '{4'h0, 4'h0, 4'h8, 4'h2};
	int          lim[4] = '{1, 12, 0, 0};
	always #20 pclk = ~pclk;
	dxt_transfer dxt_transfer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .aen(aen_m | aen_f), .dack_n(dack_n), .tc(tc),
		.ior_n(ior_n), .iow_n(iow_n), .dma_wdata(dwd), .dma_rdata(drd), .drq(drq),
		.irq(irq), .disk_rd_valid(rd_v), .disk_rd_data(rd_d), .disk_hold(hold),
		.disk_wr_take(wr_t), .disk_wr_data(wr_d), .disk_wr_avail(avail));
	dxt_isa_dma dxt_isa_dma_inst (.pclk(pclk), .presetn(presetn), .en(en), .dir(dir),
		.tc_req(tc_req), .tc_str(tc_str), .vfy(vfy), .drq(drq), .dma_rdata(drd),
		.dack_n(dack_n),
		.aen(aen_m), .tc(tc), .ior_n(ior_n), .iow_n(iow_n), .dma_wdata(dwd));
	// ----------------
	// tasks
	// ----------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
	endtask
	task wirq;
		@(posedge pclk);
		for (int n = 0; n < 3000 && irq !== 1'b1; n++)
			@(posedge pclk);
		chk(irq, 1'b1);
	endtask
	// disk source; below the trigger count no request may appear
	task dsrc(input int n, input int sl, input int lm);
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 3000 && hold !== 1'b0; k++)
				@(posedge pclk);
			b = $urandom;
			expq.push_back(b);
			rd_v <= 1'b1;
			rd_d <= b;
			@(posedge pclk);
			rd_v <= 1'b0;
			repeat (15) @(posedge pclk);
			if (i % sl + 1 < lm && i % sl + 1 < sl)
				chk(drq, 1'b0);
		end
	endtask
	task dsnk(input int n);
		for (int i = 0; i < n; i++) begin
			for (int k = 0; k < 3000 && avail !== 1'b1; k++)
				@(posedge pclk);
			wr_t <= 1'b1;
			@(posedge pclk);
			wr_t <= 1'b0;
			@(posedge pclk);
			chk(wr_d, expq.pop_front());
		end
	endtask
	task rxc;
		chk(dxt_isa_dma_inst.rxq.size(), expq.size());
		while (expq.size() > 0 && dxt_isa_dma_inst.rxq.size() > 0)
			chk(dxt_isa_dma_inst.rxq.pop_front(), expq.pop_front());
		expq.delete();
		dxt_isa_dma_inst.rxq.delete();
	endtask
	task go(input logic [6:0] f, input logic [3:0] th);
		apb(1'b1, `DXT_OFS_CTRL, {20'h0, th, 1'b0, f});
	endtask
	// ----------------
	// scenarios
	// ----------------
	initial begin
		void'($urandom(32'h7626));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdc(`DXT_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
		rdc(`DXT_OFS_SECLEN, 32'hFFFF, 32'h200);
		rdc(`DXT_OFS_SECCNT, 32'hFF, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, `DXT_OFS_SECLEN, 32'h10);
		apb(1'b1, `DXT_OFS_SECCNT, 32'h2);
		en <= 1'b1;
		tc_str <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			dir <= 1'b1;
			vfy <= (m == 2);
			go(rdm[m], rth[m]);
			dsrc(32, 16, lim[m]);
			wirq;
			rxc;
			rdc(`DXT_OFS_RESULT, 32'hFF, 32'h0);
		end
		for (int m = 0; m < 4; m++) begin
			vfy <= 1'b0;
			dir <= 1'b0;
			for (int i = 0; i < 32; i++) begin
				b = $urandom;
				expq.push_back(b);
				dxt_isa_dma_inst.wq.push_back(b);
			end
			go(wrm[m], wth[m]);
			dsnk(32);
			wirq;
			chk(dxt_isa_dma_inst.wq.size(), 0);
			rdc(`DXT_OFS_RESULT, 32'hFF, 32'h0);
		end
		fb = b;
		tc_str <= 1'b0;
		go(7'b0000111, 4'h0);
		for (int i = 0; i < 32; i++) begin
			dsrc(1, 16, 0);
			rdc(`DXT_OFS_STATUS, 32'hE0, 32'hE0);
			chk(irq, 1'b1);
			aen_f <= 1'b1;
			apb(1'b0, `DXT_OFS_DATA, 32'h0);
			aen_f <= 1'b0;
			rdc(`DXT_OFS_DATA, 32'hFF, expq.pop_front());
			@(posedge pclk);
			chk(irq, i == 31);
		end
		wirq;
		rdc(`DXT_OFS_STATUS, 32'hE0, 32'hC0);
		rdc(`DXT_OFS_RESULT, 32'hFF, 32'h0);
		@(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, `DXT_OFS_SECCNT, 32'h1);
		en <= 1'b0;
		go(7'b0001001, 4'h0);
		for (int i = 0; i < 16; i++) begin
			wr_t <= 1'b1;
			@(posedge pclk);
			wr_t <= 1'b0;
			repeat (2) @(posedge pclk);
			chk(wr_d, fb);
			chk(avail, i < 15);
		end
		wirq;
		rdc(`DXT_OFS_RESULT, 32'hFF, 32'h44);
		apb(1'b1, `DXT_OFS_SECLEN, 32'h14);
		dir <= 1'b1;
		go(7'b0011011, 4'hF);
		dsrc(20, 20, 0);
		chk(irq, 1'b0);
		repeat (4) void'(expq.pop_back());
		en <= 1'b1;
		wirq;
		rxc;
		rdc(`DXT_OFS_RESULT, 32'hFF, 32'h42);
		tc_req <= 1'b1;
		go(7'b0011011, 4'hF);
		dsrc(1, 20, 0);
		wirq;
		rxc;
		rdc(`DXT_OFS_RESULT, 32'h1, 32'h1);
		tc_req <= 1'b0;
		end_sim;
	end
	initial begin
		#2400000;
		failures++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim;
	end
endmodule
